// file: discard_timer.sv
// Delayed transaction discard timer with a selectable expiry length.
`timescale 1ns/1ns
`include "pccard_dma_diag_defs.svh"
module discard_timer #(
  parameter int SHORT_LOG2 = `DISCARD_SHORT_LOG2,
  parameter int LONG_LOG2 = `DISCARD_LONG_LOG2
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic shortSel,
  input wire logic start,
  input wire logic cancel,
  output logic expired
);
  typedef struct packed {
    pccard_dma_diag_pkg::tmr_state_t st;
    logic [LONG_LOG2:0] cnt;
    logic exp;
  } tstate_t;
  tstate_t cur_ff;
  tstate_t nxt_cur;
  logic [LONG_LOG2:0] limit;

  // A short run longer than the long run would make the select bit meaningless, so refuse it at elaboration.
  if (SHORT_LOG2 < 1 || SHORT_LOG2 > LONG_LOG2) begin : g_bad_len
    $error("discard_timer: bad lengths");
  end

  // The limit is sampled every cycle, so a change of select mid-count takes effect at once.
  assign limit = shortSel ? ((LONG_LOG2+1)'(1) << SHORT_LOG2) : ((LONG_LOG2+1)'(1) << LONG_LOG2);

  // Counts clocks from start; pulses expired once when the count reaches the limit.
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.exp = 1'b0;
    case (cur_ff.st)
      pccard_dma_diag_pkg::TMR_IDLE: begin
        if (start) begin
          nxt_cur.st = pccard_dma_diag_pkg::TMR_RUN;
          nxt_cur.cnt = (LONG_LOG2+1)'(1);
        end
      end
      pccard_dma_diag_pkg::TMR_RUN: begin
        if (cancel) begin
          nxt_cur.st = pccard_dma_diag_pkg::TMR_IDLE;
        end else if (cur_ff.cnt >= limit) begin
          nxt_cur.st = pccard_dma_diag_pkg::TMR_DONE;
          nxt_cur.exp = 1'b1;
        end else begin
          nxt_cur.cnt = cur_ff.cnt + (LONG_LOG2+1)'(1);
        end
      end
      pccard_dma_diag_pkg::TMR_DONE: begin
        nxt_cur.st = pccard_dma_diag_pkg::TMR_IDLE;
      end
      default: begin
        nxt_cur.st = pccard_dma_diag_pkg::TMR_IDLE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign expired = cur_ff.exp;
endmodule : discard_timer

// file: pc_card_model.sv
// Behavioural 16-bit card driving the pins that may carry a DMA request.
`timescale 1ns/1ns
module pc_card_model (
  input wire logic clk,
  input wire logic [2:0] lineLevels,
  output logic speaker,
  output logic ioWidth,
  output logic inputAck
);
  // The card moves its pins just after an edge, so they are never sampled mid-change.
  always_ff @(posedge clk) begin
    {speaker, ioWidth, inputAck} <= lineLevels;
  end
endmodule : pc_card_model

// file: pccard_dma_diag_config_regs.sv
// Diagnostic and socket DMA configuration registers with their controlled logic.
`timescale 1ns/1ns
`include "pccard_dma_diag_defs.svh"
module pccard_dma_diag_config_regs #(
  parameter int DISCARD_SHORT_LOG2 = `DISCARD_SHORT_LOG2,
  parameter int DISCARD_LONG_LOG2 = `DISCARD_LONG_LOG2
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  input wire logic [7:0] excaIntCtrl,
  input wire logic [7:0] excaStatusCfg,
  input wire logic statusChangeEvent,
  input wire logic cardSpeakerLine,
  input wire logic cardIoWidthLine,
  input wire logic cardInputAckLine,
  input wire logic [15:0] trueVendorId,
  input wire logic [15:0] trueDeviceId,
  input wire logic [31:0] hostIoAddr,
  input wire logic hostIoValid,
  input wire logic cbDelayedStart,
  input wire logic cbDelayedDone,
  input wire logic pciDelayedStart,
  input wire logic pciDelayedDone,
  output logic [15:0] vendorIdOut,
  output logic [15:0] deviceIdOut,
  output logic statusIrqToPci,
  output logic asyncStatusIrq,
  output logic syncStatusIrq,
  output logic delayedTxnEnable,
  output logic [6:0] retryLatencyLimit,
  output logic cbDiscardExpired,
  output logic pciDiscardExpired,
  output logic dmaRequest,
  output logic ddmaWindowHit,
  output logic [3:0] ddmaRegSelect,
  output logic xfer16Bit
);
  typedef struct packed {
    logic [7:0] diag;
    pccard_dma_diag_pkg::dma_pin_t pinSel;
    logic [11:0] winBase;
    pccard_dma_diag_pkg::xfer_width_t width;
    logic decodeEn;
    logic [31:0] rdata;
    logic [15:0] vid;
    logic [15:0] did;
    logic irqPci;
    logic irqAsync;
    logic irqSync;
    logic dtEn;
    logic [6:0] retryLim;
    logic cbExp;
    logic pciExp;
    logic dma_request;
    logic hit;
    logic [3:0] regSel;
    logic x16;
  } regs_t;
  regs_t r_ff;
  regs_t nxt_r;
  logic cbExpRaw;
  logic pciExpRaw;

  // Very long discard counts would cost flip-flops for no use, so refuse them at elaboration.
  if (DISCARD_LONG_LOG2 > 24 || DISCARD_SHORT_LOG2 < 1 || DISCARD_SHORT_LOG2 > DISCARD_LONG_LOG2) begin : g_bad_len
    $error("pccard_dma_diag_config_regs: discard lengths out of range");
  end

  // Card-side discard timer; short length when the card-side select bit is set.
  discard_timer #(
    .SHORT_LOG2(DISCARD_SHORT_LOG2),
    .LONG_LOG2(DISCARD_LONG_LOG2)
  ) u_cb_timer (
    .clk(clk),
    .rstn(rstn),
    .shortSel(r_ff.diag[`DIAG_CBTIM_BIT]),
    .start(cbDelayedStart & r_ff.dtEn),
    .cancel(cbDelayedDone),
    .expired(cbExpRaw)
  );

  // PCI-side discard timer; short length when the PCI-side select bit is set.
  discard_timer #(
    .SHORT_LOG2(DISCARD_SHORT_LOG2),
    .LONG_LOG2(DISCARD_LONG_LOG2)
  ) u_pci_timer (
    .clk(clk),
    .rstn(rstn),
    .shortSel(r_ff.diag[`DIAG_PCITIM_BIT]),
    .start(pciDelayedStart & r_ff.dtEn),
    .cancel(pciDelayedDone),
    .expired(pciExpRaw)
  );

  // Register writes, read mux and all derived outputs; every output is registered.
  always_comb begin
    nxt_r = r_ff;
    nxt_r.rdata = 32'h00000000;
    if (regWrite) begin
      case (regAddr)
        `DIAG_OFFSET: begin
          nxt_r.diag = regWdata[7:0] & `DIAG_WMASK;
        end
        `DMA_SEL_OFFSET: begin
          nxt_r.pinSel = pccard_dma_diag_pkg::dma_pin_t'(regWdata[1:0]);
        end
        `DMA_WIN_OFFSET: begin
          nxt_r.winBase = regWdata[15:4];
          nxt_r.width = pccard_dma_diag_pkg::xfer_width_t'(regWdata[2:1]);
          nxt_r.decodeEn = regWdata[0];
        end
        default: begin
        end
      endcase
    end
    // Reads answer in the next cycle only; unmapped offsets read as zero.
    if (regRead) begin
      case (regAddr)
        `DIAG_OFFSET: begin
          nxt_r.rdata = {24'h000000, r_ff.diag & `DIAG_WMASK};
        end
        `DMA_SEL_OFFSET: begin
          nxt_r.rdata = {30'h00000000, r_ff.pinSel};
        end
        `DMA_WIN_OFFSET: begin
          nxt_r.rdata = {16'h0000, r_ff.winBase, 1'b0, r_ff.width, r_ff.decodeEn};
        end
        default: begin
          nxt_r.rdata = 32'h00000000;
        end
      endcase
    end
    // Identity override forces all ones on both identity registers.
    nxt_r.vid = r_ff.diag[`DIAG_IDOVR_BIT] ? 16'hffff : trueVendorId;
    nxt_r.did = r_ff.diag[`DIAG_IDOVR_BIT] ? 16'hffff : trueDeviceId;
    // Routing gate; with the route bit set the 803 enable bit is ignored.
    if (r_ff.diag[`DIAG_ROUTE_BIT]) begin
      nxt_r.irqPci = statusChangeEvent & (excaStatusCfg[7:4] == 4'h0);
    end else begin
      nxt_r.irqPci = statusChangeEvent & excaIntCtrl[`EXCA_ENABLE_BIT];
    end
    // Asynchronous generation is the default; otherwise the interrupt goes out on the synchronous path.
    nxt_r.irqAsync = nxt_r.irqPci & r_ff.diag[`DIAG_ASYNC_BIT];
    nxt_r.irqSync = nxt_r.irqPci & ~r_ff.diag[`DIAG_ASYNC_BIT];
    nxt_r.dtEn = ~r_ff.diag[`DIAG_DTDIS_BIT];
    nxt_r.retryLim = r_ff.diag[`DIAG_REXT_BIT] ? `RETRY_LONG : `RETRY_SHORT;
    nxt_r.cbExp = cbExpRaw;
    nxt_r.pciExp = pciExpRaw;
    // Request pin mux; a socket not set up for DMA never requests.
    case (r_ff.pinSel)
      pccard_dma_diag_pkg::PIN_SPEAKER: nxt_r.dma_request = cardSpeakerLine;
      pccard_dma_diag_pkg::PIN_IO_WIDTH: nxt_r.dma_request = cardIoWidthLine;
      pccard_dma_diag_pkg::PIN_INPUT_ACK: nxt_r.dma_request = cardInputAckLine;
      default: nxt_r.dma_request = 1'b0;
    endcase
    // Window decode: upper 16 address bits must be zero, base compares bits 15-4.
    nxt_r.hit = r_ff.decodeEn & hostIoValid & (hostIoAddr[31:16] == 16'h0000)
      & (hostIoAddr[15:4] == r_ff.winBase);
    nxt_r.regSel = hostIoAddr[3:0];
    // Reserved width codes fall back to 8-bit; nothing wider than 16 bits exists.
    nxt_r.x16 = (r_ff.width == pccard_dma_diag_pkg::WIDTH_16);
  end

  // Single state register for the whole block except the two discard timers, which keep their own.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r_ff <= '0;
      r_ff.diag <= `DIAG_RESET;
      r_ff.pinSel <= pccard_dma_diag_pkg::dma_pin_t'(`SEL_RESET);
      r_ff.winBase <= `WIN_BASE_RESET;
      r_ff.width <= pccard_dma_diag_pkg::xfer_width_t'(`WIN_WIDTH_RESET);
      r_ff.dtEn <= 1'b1;
      r_ff.retryLim <= `RETRY_SHORT;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign regRdata = r_ff.rdata;
  assign vendorIdOut = r_ff.vid;
  assign deviceIdOut = r_ff.did;
  assign statusIrqToPci = r_ff.irqPci;
  assign asyncStatusIrq = r_ff.irqAsync;
  assign syncStatusIrq = r_ff.irqSync;
  assign delayedTxnEnable = r_ff.dtEn;
  assign retryLatencyLimit = r_ff.retryLim;
  assign cbDiscardExpired = r_ff.cbExp;
  assign pciDiscardExpired = r_ff.pciExp;
  assign dmaRequest = r_ff.dma_request;
  assign ddmaWindowHit = r_ff.hit;
  assign ddmaRegSelect = r_ff.regSel;
  assign xfer16Bit = r_ff.x16;
endmodule : pccard_dma_diag_config_regs

// file: pccard_dma_diag_config_regs_assertions.sv
// Port-level assertions for the configuration register block.
`timescale 1ns/1ns
module pccard_dma_diag_chk (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] regAddr,
  input wire logic regRead,
  input wire logic [31:0] regRdata,
  input wire logic [15:0] trueVendorId,
  input wire logic [15:0] vendorIdOut,
  input wire logic statusChangeEvent,
  input wire logic statusIrqToPci,
  input wire logic asyncStatusIrq,
  input wire logic syncStatusIrq,
  input wire logic [6:0] retryLatencyLimit,
  input wire logic [31:0] hostIoAddr,
  input wire logic hostIoValid,
  input wire logic ddmaWindowHit,
  input wire logic [3:0] ddmaRegSelect,
  input wire logic cbDiscardExpired
);
  // One clock domain, so clocking and reset are declared once.
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Reserved bits of every read word stay clear whatever was written.
  property p_selRsvd; $past(regRead && regAddr == 8'h94) |-> regRdata[31:2] == 30'h0; endproperty
  a_selRsvd: assert property (p_selRsvd) else $error("select word reserved bits set");
  property p_winRsvd; $past(regRead && regAddr == 8'h98) |-> regRdata[31:16] == 16'h0 && !regRdata[3]; endproperty
  a_winRsvd: assert property (p_winRsvd) else $error("window word reserved bits set");
  property p_diagRsvd; $past(regRead && regAddr == 8'h93) |-> !regRdata[6]; endproperty
  a_diagRsvd: assert property (p_diagRsvd) else $error("diagnostic bit 6 set");
  // Identity output is either the true value or all ones, nothing else.
  // The identity output still holds its reset value at the first edge after reset.
  property p_idOvr; $past(rstn) |-> vendorIdOut == 16'hffff || vendorIdOut == $past(trueVendorId); endproperty
  a_idOvr: assert property (p_idOvr) else $error("identity output corrupt");
  // A routed status interrupt leaves by exactly one of the two strobes.
  property p_irqSplit; statusIrqToPci == (asyncStatusIrq ^ syncStatusIrq); endproperty
  a_irqSplit: assert property (p_irqSplit) else $error("status strobes disagree");
  property p_irqCause; statusIrqToPci |-> $past(statusChangeEvent); endproperty
  a_irqCause: assert property (p_irqCause) else $error("status interrupt without event");
  property p_retry; retryLatencyLimit == 7'h10 || retryLatencyLimit == 7'h40; endproperty
  a_retry: assert property (p_retry) else $error("retry limit not 16 or 64");
  // A hit needs a valid access below 64K and selects by the low nibble.
  property p_hit; ddmaWindowHit |-> $past(hostIoValid) && $past(hostIoAddr[31:16]) == 16'h0
    && ddmaRegSelect == $past(hostIoAddr[3:0]); endproperty
  a_hit: assert property (p_hit) else $error("window hit outside window");
  property p_pulse; cbDiscardExpired |=> !cbDiscardExpired; endproperty
  a_pulse: assert property (p_pulse) else $error("discard expiry not a pulse");
endmodule : pccard_dma_diag_chk

// file: pccard_dma_diag_defs.svh
// Constants for the diagnostic and socket DMA configuration registers.
`ifndef PCCARD_DMA_DIAG_DEFS_SVH
`define PCCARD_DMA_DIAG_DEFS_SVH
`define DIAG_OFFSET 8'h93
`define DMA_SEL_OFFSET 8'h94
`define DMA_WIN_OFFSET 8'h98
`define DIAG_RESET 8'h21
`define DIAG_WMASK 8'hbf
`define DIAG_IDOVR_BIT 7
`define DIAG_ROUTE_BIT 5
`define DIAG_DTDIS_BIT 4
`define DIAG_REXT_BIT 3
`define DIAG_CBTIM_BIT 2
`define DIAG_PCITIM_BIT 1
`define DIAG_ASYNC_BIT 0
`define SEL_RESET 2'h0
`define WIN_BASE_RESET 12'h000
`define WIN_WIDTH_RESET 2'h0
`define RETRY_SHORT 7'h10
`define RETRY_LONG 7'h40
`define DISCARD_SHORT_LOG2 10
`define DISCARD_LONG_LOG2 15
`define EXCA_ENABLE_BIT 4
`endif

// file: pccard_dma_diag_pkg.sv
// Types shared by the configuration register block.
package pccard_dma_diag_pkg;
  typedef enum logic [1:0] {PIN_NONE, PIN_SPEAKER, PIN_IO_WIDTH, PIN_INPUT_ACK} dma_pin_t;
  typedef enum logic [1:0] {WIDTH_8, WIDTH_16, WIDTH_RSVD2, WIDTH_RSVD3} xfer_width_t;
  typedef enum logic [1:0] {TMR_IDLE, TMR_RUN, TMR_DONE} tmr_state_t;
endpackage : pccard_dma_diag_pkg

// file: tb_pccard_dma_diag_config_regs.sv
// Self-checking bench for the diagnostic and socket DMA configuration registers.
`timescale 1ns/1ns
`include "pccard_dma_diag_defs.svh"
module tb_pccard_dma_diag_config_regs;
  localparam int SH = 2;
  localparam int LG = 4;
  logic clk, rstn, regWrite, regRead, statusChangeEvent, hostIoValid;
  logic cardSpeakerLine, cardIoWidthLine, cardInputAckLine;
  logic cbDelayedStart, cbDelayedDone, pciDelayedStart, pciDelayedDone;
  logic [7:0] regAddr, excaIntCtrl, excaStatusCfg;
  logic [31:0] regWdata, regRdata, hostIoAddr;
  logic [15:0] trueVendorId, trueDeviceId, vendorIdOut, deviceIdOut;
  logic statusIrqToPci, asyncStatusIrq, syncStatusIrq, delayedTxnEnable;
  logic cbDiscardExpired, pciDiscardExpired, dmaRequest, ddmaWindowHit, xfer16Bit;
  logic [6:0] retryLatencyLimit;
  logic [3:0] ddmaRegSelect;
  logic [2:0] lineLevels;
  int n_fail, n_compared;
  // Short discard lengths keep the timer runs brief.
  pccard_dma_diag_config_regs #(.DISCARD_SHORT_LOG2(SH), .DISCARD_LONG_LOG2(LG)) dut (.*);
  pc_card_model card (.clk(clk), .lineLevels(lineLevels), .speaker(cardSpeakerLine),
    .ioWidth(cardIoWidthLine), .inputAck(cardInputAckLine));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    chk(regRdata, exp);
  endtask : rd
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask : settle
  task automatic t_diag;
    rd(`DIAG_OFFSET, 32'h21);
    chk(retryLatencyLimit, 7'h10);
    wr(`DIAG_OFFSET, 32'hff);
    rd(`DIAG_OFFSET, 32'hbf);
    chk(vendorIdOut, 16'hffff);
    chk(deviceIdOut, 16'hffff);
    chk(delayedTxnEnable, 1'b0);
    chk(retryLatencyLimit, 7'h40);
    wr(`DIAG_OFFSET, 32'h0);
    rd(8'h95, 32'h0);
    chk(vendorIdOut, trueVendorId);
    chk(deviceIdOut, trueDeviceId);
    chk(delayedTxnEnable, 1'b1);
    $display("diag test done");
  endtask : t_diag
  task automatic t_sel;
    rd(`DMA_SEL_OFFSET, 32'h0);
    for (int c = 0; c < 4; c++) begin
      wr(`DMA_SEL_OFFSET, 32'hffff_fffc | c);
      rd(`DMA_SEL_OFFSET, c);
      for (int p = 0; p < 2; p++) begin
        lineLevels <= p ? 3'b101 : 3'b010;
        settle;
        chk(dmaRequest, (c == 0) ? 1'b0 : lineLevels[3 - c]);
      end
    end
    $display("select test done");
  endtask : t_sel
  task automatic t_win;
    wr(`DMA_WIN_OFFSET, 32'hffff_ffff);
    rd(`DMA_WIN_OFFSET, 32'h0000_fff7);
    wr(`DMA_WIN_OFFSET, 32'h0000_1235);
    rd(`DMA_WIN_OFFSET, 32'h0000_1235);
    chk(xfer16Bit, 1'b0);
    wr(`DMA_WIN_OFFSET, 32'h0000_1233);
    rd(`DMA_WIN_OFFSET, 32'h0000_1233);
    chk(xfer16Bit, 1'b1);
    hostIoAddr <= 32'h0000_123a;
    hostIoValid <= 1'b1;
    settle;
    chk({ddmaWindowHit, ddmaRegSelect}, 5'h1a);
    hostIoAddr <= 32'h0001_123a;
    settle;
    chk(ddmaWindowHit, 1'b0);
    hostIoAddr <= 32'h0000_123a;
    wr(`DMA_WIN_OFFSET, 32'h0000_1232);
    settle;
    chk(ddmaWindowHit, 1'b0);
    hostIoValid <= 1'b0;
    $display("window test done");
  endtask : t_win
  // Each entry: diagnostic value, two ExCA levels, then routed, async and sync strobes.
  task automatic t_irq;
    logic [26:0] tv [5] = '{{8'h21, 8'h00, 8'h00, 3'b110}, {8'h21, 8'h10, 8'h10, 3'b000},
      {8'h20, 8'h00, 8'h00, 3'b101}, {8'h01, 8'h10, 8'hf0, 3'b110}, {8'h01, 8'h00, 8'h00, 3'b000}};
    for (int i = 0; i < 5; i++) begin
      excaIntCtrl <= tv[i][18:11];
      excaStatusCfg <= tv[i][10:3];
      wr(`DIAG_OFFSET, tv[i][26:19]);
      @(posedge clk);
      statusChangeEvent <= 1'b1;
      @(posedge clk);
      statusChangeEvent <= 1'b0;
      #1;
      chk({statusIrqToPci, asyncStatusIrq, syncStatusIrq}, tv[i][2:0]);
    end
    $display("irq test done");
  endtask : t_irq
  // Counts edges from the start strobe to the expiry pulse, 40 meaning none came.
  task automatic t_tmr(input logic cb, input int lo, input int hi);
    int n;
    @(posedge clk);
    cbDelayedStart <= cb;
    pciDelayedStart <= !cb;
    @(posedge clk);
    cbDelayedStart <= 1'b0;
    pciDelayedStart <= 1'b0;
    #1;
    n = 0;
    while (!(cb ? cbDiscardExpired : pciDiscardExpired) && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(n >= lo && n <= hi, 1'b1);
  endtask : t_tmr
  task automatic t_timers;
    wr(`DIAG_OFFSET, 32'h04);
    t_tmr(1'b1, 2 ** SH, 2 ** SH + 2);
    t_tmr(1'b0, 2 ** LG, 2 ** LG + 2);
    wr(`DIAG_OFFSET, 32'h02);
    t_tmr(1'b1, 2 ** LG, 2 ** LG + 2);
    t_tmr(1'b0, 2 ** SH, 2 ** SH + 2);
    // A completed transaction cancels the count, so no expiry may follow it.
    @(posedge clk);
    cbDelayedStart <= 1'b1;
    @(posedge clk);
    cbDelayedStart <= 1'b0;
    cbDelayedDone <= 1'b1;
    @(posedge clk);
    cbDelayedDone <= 1'b0;
    repeat (2 ** LG + 4) begin
      @(posedge clk);
      #1;
      chk(cbDiscardExpired, 1'b0);
    end
    wr(`DIAG_OFFSET, 32'h14);
    t_tmr(1'b1, 40, 40);
    $display("timer test done");
  endtask : t_timers
  task automatic results;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  // Identity values are arbitrary test patterns.
  initial begin
    {rstn, regWrite, regRead, statusChangeEvent, hostIoValid} = '0;
    {cbDelayedStart, cbDelayedDone, pciDelayedStart, pciDelayedDone} = '0;
    {regAddr, excaIntCtrl, excaStatusCfg, regWdata, hostIoAddr, lineLevels} = '0;
    trueVendorId = 16'h5a3c;
    trueDeviceId = 16'hc3a5;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    t_diag();
    t_sel();
    t_win();
    t_irq();
    t_timers();
    results();
  end
  // The tests need well under a thousand cycles; five thousand means a hang.
  initial begin
    #(50 * 5000);
    n_fail++;
    results();
  end
endmodule : tb_pccard_dma_diag_config_regs
bind pccard_dma_diag_config_regs pccard_dma_diag_chk portCheck (.*);
